// File: logic/dwc_top.v
// Debug watchpoint control: two coupled watchpoints, debug control and status
`timescale 1ns/10ps
`default_nettype none
`include "dwc_map.vh"
// What this block does
// R1: Exact address watch: value loaded, mask zero
// R2: Data mask all ones ignores data
// R3: Control value selects fetch, direction, size
// R4: Control mask zero on watched fields
// R5: Set address mask bits are ignored
// R6: Three-bit control: irq block, request, acknowledge
// R7: Selector high writes control, low reads
// R8: Irq permit low on acknowledge or block
// R9: Synced request ORed with pin, driven out
// R10: Request latch opens only in idle state
// R11: Acknowledge out is core ack OR bit0
// R12: Five-bit status register, writable with selector
// R13: Status request, ack, done synced to tck
// R14: Address match loads data match into link
// R15: Watchpoint 1 link feeds watchpoint 0
// R16: Watchpoint 1 span feeds watchpoint 0
// R17: Ranges are power-of-two masked regions
// R18: Disabled watchpoint still drives span output
// R19: Span input matched at zero triggers
// R20: Extern inputs taken at core clock fall
// R21: Watchpoints programmed only while core stopped; the block accepts watchpoint writes at any time
// R22: Control and status accessible any time
// R23: Break only when enable bit set
// R24: Link cleared on watchpoint control value write or trst
// R25: Each control value bit except enable has a mask bit

module dwc_top (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        tck,
  input  wire        trst_b,
  input  wire        tap_idle,
  input  wire        reg_update,
  input  wire        reg_write,
  input  wire [4:0]  reg_select,
  input  wire [31:0] reg_wdata,
  input  wire        core_debug_clock,
  input  wire [31:0] core_addr,
  input  wire [31:0] core_data,
  input  wire        fetch_n,
  input  wire        direction_n,
  input  wire [1:0]  access_size,
  input  wire        privilege_n,
  input  wire [1:0]  watch_extern,
  input  wire        halt_request,
  input  wire        core_halt_acknowledge,
  input  wire        compact_isa_state,
  input  wire        memory_request_n,
  output reg  [31:0] reg_rdata,
  output reg         halt_request_internal,
  output reg         halt_acknowledge,
  output reg         irq_permit,
  output reg         break_hit
);

  // ========================================================================
  // Input synchronisers
  localparam SYNC_W = 118;

  wire [SYNC_W-1:0] pin_raw;
  reg  [SYNC_W-1:0] pin_meta;
  reg  [SYNC_W-1:0] pin_sync;

  // All pins except clk and rst_b in one vector so every one passes the same two stages
  assign pin_raw = {tck, trst_b, tap_idle, reg_update, reg_write, reg_select,
                    reg_wdata, core_debug_clock, core_addr, core_data,
                    fetch_n, direction_n, access_size, privilege_n,
                    watch_extern, halt_request, core_halt_acknowledge,
                    compact_isa_state, memory_request_n};

  // Two flip-flops; only the second stage is read by logic
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta <= {SYNC_W{1'b0}};
      pin_sync <= {SYNC_W{1'b0}};
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // Named slices of the synchronised vector
  wire        s_tck;
  wire        s_trst_b;
  wire        s_tap_idle;
  wire        s_update;
  wire        s_write;
  wire [4:0]  s_select;
  wire [31:0] s_wdata;
  wire        s_core_clk;
  wire [31:0] s_addr;
  wire [31:0] s_data;
  wire        s_fetch_n;
  wire        s_direction_n;
  wire [1:0]  s_size;
  wire        s_privilege_n;
  wire [1:0]  s_extern;
  wire        s_halt_request;
  wire        s_core_ack;
  wire        s_isa;
  wire        s_mreq_n;

  assign s_tck          = pin_sync[117];
  assign s_trst_b       = pin_sync[116];
  assign s_tap_idle     = pin_sync[115];
  assign s_update       = pin_sync[114];
  assign s_write        = pin_sync[113];
  assign s_select       = pin_sync[112:108];
  assign s_wdata        = pin_sync[107:76];
  assign s_core_clk     = pin_sync[75];
  assign s_addr         = pin_sync[74:43];
  assign s_data         = pin_sync[42:11];
  assign s_fetch_n      = pin_sync[10];
  assign s_direction_n  = pin_sync[9];
  assign s_size         = pin_sync[8:7];
  assign s_privilege_n  = pin_sync[6];
  assign s_extern       = pin_sync[5:4];
  assign s_halt_request = pin_sync[3];
  assign s_core_ack     = pin_sync[2];
  assign s_isa          = pin_sync[1];
  assign s_mreq_n       = pin_sync[0];

  // ========================================================================
  // Clock edge detection on the two sampled clocks
  reg tck_prev;
  reg core_clk_prev;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tck_prev      <= 1'b0;
      core_clk_prev <= 1'b0;
    end else begin
      tck_prev      <= s_tck;
      core_clk_prev <= s_core_clk;
    end
  end

  wire tck_rise;
  wire core_fall;
  wire access;
  wire wr_access;
  wire rd_access;

  assign tck_rise  = s_tck & ~tck_prev;
  assign core_fall = core_clk_prev & ~s_core_clk;
  // Register access completes on a test clock rise with update high
  assign access    = tck_rise & s_update & s_trst_b;
  assign wr_access = access & s_write; // R7 R12
  assign rd_access = access & ~s_write; // R7

  // ========================================================================
  // Watchpoint register storage
  reg [31:0] wp_addr_value [0:1];
  reg [31:0] wp_addr_mask  [0:1];
  reg [31:0] wp_data_value [0:1];
  reg [31:0] wp_data_mask  [0:1];
  reg [8:0]  wp_ctrl_value [0:1];
  reg [7:0]  wp_ctrl_mask  [0:1];
  reg [1:0]  ctrl_value_wr;

  // Which watchpoint a select addresses, or none
  function [1:0] wp_hit;
    input [4:0] sel;
    begin
      wp_hit[0] = (sel[4:3] == `DWC_REG_WP0_BASE >> 3) && (sel[2:0] <= `DWC_OFS_CTRL_MASK);
      wp_hit[1] = (sel[4:3] == `DWC_REG_WP1_BASE >> 3) && (sel[2:0] <= `DWC_OFS_CTRL_MASK);
    end
  endfunction

  integer i;

  // Debugger loads comparator values; keeping the core stopped is its duty
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (i = 0; i < 2; i = i + 1) begin
        wp_addr_value[i] <= `DWC_VALUE_RST;
        wp_addr_mask[i]  <= `DWC_MASK_RST;
        wp_data_value[i] <= `DWC_VALUE_RST;
        wp_data_mask[i]  <= `DWC_MASK_RST;
        wp_ctrl_value[i] <= `DWC_CV_RST;
        wp_ctrl_mask[i]  <= `DWC_CM_RST;
      end
      ctrl_value_wr <= 2'b00;
    end else begin
      ctrl_value_wr <= 2'b00;
      for (i = 0; i < 2; i = i + 1) begin
        if (wr_access && wp_hit(s_select) == (2'b01 << i)) begin // R21
          case (s_select[2:0])
            `DWC_OFS_ADDR_VALUE: wp_addr_value[i] <= s_wdata; // R1
            `DWC_OFS_ADDR_MASK:  wp_addr_mask[i]  <= s_wdata; // R1 R17
            `DWC_OFS_DATA_VALUE: wp_data_value[i] <= s_wdata; // R2
            `DWC_OFS_DATA_MASK:  wp_data_mask[i]  <= s_wdata; // R2
            `DWC_OFS_CTRL_VALUE: begin
              wp_ctrl_value[i] <= s_wdata[`DWC_CV_W-1:0]; // R3
              ctrl_value_wr[i] <= 1'b1;
            end
            `DWC_OFS_CTRL_MASK:  wp_ctrl_mask[i]  <= s_wdata[`DWC_CM_W-1:0]; // R4 R25
            default: wp_addr_value[i] <= wp_addr_value[i];
          endcase
        end
      end
    end
  end

  // ========================================================================
  // Core bus capture on the falling edge of the core debug clock
  reg [31:0] cap_addr;
  reg [31:0] cap_data;
  reg [4:0]  cap_ctrl;
  reg [1:0]  cap_extern;
  reg        eval;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cap_addr   <= 32'h0000_0000;
      cap_data   <= 32'h0000_0000;
      cap_ctrl   <= 5'h00;
      cap_extern <= 2'h0;
      eval       <= 1'b0;
    end else begin
      eval <= core_fall;
      if (core_fall) begin
        cap_addr   <= s_addr;
        cap_data   <= s_data;
        cap_ctrl   <= {s_privilege_n, s_fetch_n, s_size, s_direction_n};
        cap_extern <= s_extern; // R20
      end
    end
  end

  // ========================================================================
  // Two watchpoints, unit 1 coupled into unit 0
  wire       link_1;
  wire       span_1;
  wire       trig_1;
  wire       trig_0;
  wire [7:0] bus_ctrl_0;
  wire [7:0] bus_ctrl_1;

  // Unit 1 has neither link nor span input
  assign bus_ctrl_1 = {1'b0, 1'b0, cap_extern[1], cap_ctrl};
  assign bus_ctrl_0 = {span_1, link_1, cap_extern[0], cap_ctrl}; // R15 R16 R19

  dwc_watch #(
    .HAS_LINK (1)
  ) u_watch_1 (
    .clk        (clk),
    .rst_b      (rst_b),
    .addr_value (wp_addr_value[1]),
    .addr_mask  (wp_addr_mask[1]),
    .data_value (wp_data_value[1]),
    .data_mask  (wp_data_mask[1]),
    .ctrl_value (wp_ctrl_value[1]),
    .ctrl_mask  (wp_ctrl_mask[1]),
    .bus_addr   (cap_addr),
    .bus_data   (cap_data),
    .bus_ctrl   (bus_ctrl_1),
    .eval       (eval),
    .link_clear (ctrl_value_wr[1] | ~s_trst_b), // R24
    .link_out   (link_1),
    .span_out   (span_1),
    .trigger    (trig_1)
  );

  // Unit 0 has no link output of its own
  dwc_watch #(
    .HAS_LINK (0)
  ) u_watch_0 (
    .clk        (clk),
    .rst_b      (rst_b),
    .addr_value (wp_addr_value[0]),
    .addr_mask  (wp_addr_mask[0]),
    .data_value (wp_data_value[0]),
    .data_mask  (wp_data_mask[0]),
    .ctrl_value (wp_ctrl_value[0]),
    .ctrl_mask  (wp_ctrl_mask[0]),
    .bus_addr   (cap_addr),
    .bus_data   (cap_data),
    .bus_ctrl   (bus_ctrl_0),
    .eval       (eval),
    .link_clear (ctrl_value_wr[0] | ~s_trst_b), // R24
    .link_out   (),
    .span_out   (),
    .trigger    (trig_0)
  );

  // Break decided once per core clock fall, held until the next one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      break_hit <= 1'b0;
    end else if (eval) begin
      break_hit <= trig_0 | trig_1; // R23 R18 R19
    end
  end

  // ========================================================================
  // Debug control register and forced request latch
  reg [2:0] debug_control;
  reg       forced_request;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_control <= `DWC_CTRL_RST;
    end else if (!s_trst_b) begin
      debug_control <= `DWC_CTRL_RST;
    end else if (wr_access && s_select == `DWC_REG_CONTROL) begin
      debug_control <= s_wdata[`DWC_CTRL_W-1:0]; // R6 R7 R22
    end
  end

  // Latch is transparent only in Run-Test/Idle so many cores enter together
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      forced_request <= 1'b0;
    end else if (s_tap_idle) begin
      forced_request <= debug_control[`DWC_CTRL_HALT_REQ]; // R10
    end
  end

  // ========================================================================
  // Request, acknowledge and interrupt permit outputs
  wire next_halt_request;
  wire next_halt_ack;
  wire next_irq_permit;

  assign next_halt_request = forced_request | s_halt_request; // R9
  assign next_halt_ack     = s_core_ack | debug_control[`DWC_CTRL_HALT_ACK]; // R11
  // Both interrupt kinds are blocked while debugging or when blocked by bit 2
  assign next_irq_permit   = ~(next_halt_ack | debug_control[`DWC_CTRL_IRQ_BLOCK]); // R8

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_request_internal <= 1'b0;
      halt_acknowledge      <= 1'b0;
      irq_permit            <= 1'b1;
    end else begin
      halt_request_internal <= next_halt_request; // R9
      halt_acknowledge      <= next_halt_ack; // R11
      irq_permit            <= next_irq_permit; // R8
    end
  end

  // ========================================================================
  // Debug status register, refreshed on every test clock rise that is not a status write
  reg [4:0] debug_status;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      debug_status <= `DWC_STAT_RST;
    end else if (wr_access && s_select == `DWC_REG_STATUS) begin
      debug_status <= s_wdata[`DWC_STAT_W-1:0]; // R12
    end else if (tck_rise) begin
      debug_status[`DWC_STAT_ISA]        <= s_isa; // R12
      debug_status[`DWC_STAT_DONE]       <= s_mreq_n; // R13
      debug_status[`DWC_STAT_IRQ_PERMIT] <= irq_permit; // R12
      debug_status[`DWC_STAT_HALT_REQ]   <= halt_request_internal; // R13
      debug_status[`DWC_STAT_HALT_ACK]   <= halt_acknowledge; // R13
    end
  end

  // ========================================================================
  // Read data path
  reg [31:0] next_rdata;
  integer    j;

  // Unmapped selects and reserved bits read as zero
  always @* begin
    next_rdata = 32'h0000_0000;
    if (s_select == `DWC_REG_CONTROL) begin
      next_rdata[`DWC_CTRL_W-1:0] = debug_control; // R7 R22
    end else if (s_select == `DWC_REG_STATUS) begin
      next_rdata[`DWC_STAT_W-1:0] = debug_status; // R12
    end else begin
      for (j = 0; j < 2; j = j + 1) begin
        if (wp_hit(s_select) == (2'b01 << j)) begin
          case (s_select[2:0])
            `DWC_OFS_ADDR_VALUE: next_rdata = wp_addr_value[j];
            `DWC_OFS_ADDR_MASK:  next_rdata = wp_addr_mask[j];
            `DWC_OFS_DATA_VALUE: next_rdata = wp_data_value[j];
            `DWC_OFS_DATA_MASK:  next_rdata = wp_data_mask[j];
            `DWC_OFS_CTRL_VALUE: next_rdata[`DWC_CV_W-1:0] = wp_ctrl_value[j];
            `DWC_OFS_CTRL_MASK:  next_rdata[`DWC_CM_W-1:0] = wp_ctrl_mask[j];
            default:             next_rdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // Read data is loaded on a read access and held until the next one
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0000_0000;
    end else if (rd_access) begin
      reg_rdata <= next_rdata; // R7
    end
  end

endmodule // dwc_top

`default_nettype wire

// File: logic/dwc_map.vh
// Register indices, field positions, widths and reset values of the debug watchpoint block
`ifndef DWC_MAP_VH
`define DWC_MAP_VH

// ==========================================================================
// Register indices on the scan register port
`define DWC_SEL_W            5
`define DWC_REG_CONTROL      5'h00
`define DWC_REG_STATUS       5'h01
`define DWC_REG_WP0_BASE     5'h08
`define DWC_REG_WP1_BASE     5'h10
`define DWC_OFS_ADDR_VALUE   3'h0
`define DWC_OFS_ADDR_MASK    3'h1
`define DWC_OFS_DATA_VALUE   3'h2
`define DWC_OFS_DATA_MASK    3'h3
`define DWC_OFS_CTRL_VALUE   3'h4
`define DWC_OFS_CTRL_MASK    3'h5

// ==========================================================================
// Debug control register fields
`define DWC_CTRL_W           3
`define DWC_CTRL_IRQ_BLOCK   2
`define DWC_CTRL_HALT_REQ    1
`define DWC_CTRL_HALT_ACK    0
`define DWC_CTRL_RST         3'h0

// ==========================================================================
// Debug status register fields
`define DWC_STAT_W           5
`define DWC_STAT_ISA         4
`define DWC_STAT_DONE        3
`define DWC_STAT_IRQ_PERMIT  2
`define DWC_STAT_HALT_REQ    1
`define DWC_STAT_HALT_ACK    0
`define DWC_STAT_RST         5'h00

// ==========================================================================
// Watchpoint control value and mask fields
`define DWC_CV_W             9
`define DWC_CM_W             8
`define DWC_CV_DIRECTION     0
`define DWC_CV_SIZE_LO       1
`define DWC_CV_SIZE_HI       2
`define DWC_CV_FETCH         3
`define DWC_CV_PRIVILEGE     4
`define DWC_CV_EXTERN        5
`define DWC_CV_LINK          6
`define DWC_CV_SPAN          7
`define DWC_CV_ENABLE        8
`define DWC_CV_RST           9'h000
`define DWC_CM_RST           8'hff
`define DWC_VALUE_RST        32'h0000_0000
`define DWC_MASK_RST         32'hffff_ffff

`endif

// File: logic/dwc_watch.v
// One watchpoint comparator unit with link latch and span output
`timescale 1ns/10ps
`default_nettype none
`include "dwc_map.vh"

module dwc_watch #(
  parameter HAS_LINK = 1
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire [31:0] addr_value,
  input  wire [31:0] addr_mask,
  input  wire [31:0] data_value,
  input  wire [31:0] data_mask,
  input  wire [8:0]  ctrl_value,
  input  wire [7:0]  ctrl_mask,
  input  wire [31:0] bus_addr,
  input  wire [31:0] bus_data,
  input  wire [7:0]  bus_ctrl,
  input  wire        eval,
  input  wire        link_clear,
  output reg         link_out,
  output wire        span_out,
  output wire        trigger
);

  // ========================================================================
  // Compare
  wire addr_side;
  wire data_side;

  // Every bit equal or masked out; shared by both comparator halves
  function all_match;
    input [36:0] v;
    input [36:0] b;
    input [36:0] m;
    begin
      all_match = &((v ~^ b) | m);
    end
  endfunction

  // Address half covers control bits 4:0, mask bit set ignores that bit
  assign addr_side = all_match({addr_value, ctrl_value[4:0]},
                               {bus_addr, bus_ctrl[4:0]},
                               {addr_mask, ctrl_mask[4:0]}); // R5 R25 R17
  // Data half covers control bits 7:5, padding bits forced to match
  assign data_side = all_match({2'b00, data_value, ctrl_value[7:5]},
                               {2'b00, bus_data, bus_ctrl[7:5]},
                               {2'b11, data_mask, ctrl_mask[7:5]}); // R25

  // Span is the full match, whatever the enable bit says
  assign span_out = addr_side & data_side; // R16 R18
  // Enable bit lives only in the value register and is never masked
  assign trigger  = span_out & ctrl_value[`DWC_CV_ENABLE]; // R23 R18

  // ========================================================================
  // Link latch: address half opens it, data half is what it stores
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_out <= 1'b0;
    end else if (link_clear) begin
      link_out <= 1'b0; // R24
    end else if (eval && addr_side) begin
      link_out <= (HAS_LINK != 0) ? data_side : 1'b0; // R14 R15
    end
  end

endmodule // dwc_watch

`default_nettype wire

// File: test/dwc_top_monitor.sv
// Port checker of the debug watchpoint control block
`timescale 1ns/10ps
`default_nettype none
module dwc_top_monitor (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        tck,
  input wire logic        trst_b,
  input wire logic        tap_idle,
  input wire logic        core_debug_clock,
  input wire logic        halt_request,
  input wire logic        core_halt_acknowledge,
  input wire logic [31:0] reg_rdata,
  input wire logic        halt_request_internal,
  input wire logic        halt_acknowledge,
  input wire logic        irq_permit,
  input wire logic        break_hit
);
  // ==========================================================================
  // Output relations on the system clock
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_ack_blocks_irq: assert property (halt_acknowledge [*2] |-> !irq_permit)
    else $error("irq_permit high with ack");
  a_ack_follows_core: assert property (core_halt_acknowledge [*4] |-> halt_acknowledge)
    else $error("core ack not passed");
  a_req_follows_pin: assert property (halt_request [*4] |-> halt_request_internal)
    else $error("request pin not passed");
  a_req_gate_idle: assert property ($rose(halt_request_internal) |->
    $past(tap_idle, 2) || $past(tap_idle, 3) || $past(tap_idle, 4) || $past(tap_idle, 5)
    || $past(halt_request, 2) || $past(halt_request, 3) || $past(halt_request, 4))
    else $error("request rose outside idle");
  a_ack_has_cause: assert property ($rose(halt_acknowledge) |->
    $past(core_halt_acknowledge, 2) || $past(core_halt_acknowledge, 3)
    || $past(core_halt_acknowledge, 4) || $past(tck, 2) || $past(tck, 3)
    || $past(tck, 4) || $past(tck, 5))
    else $error("ack rose without cause");
  a_rdata_on_tck: assert property ($stable(tck) [*8] |-> $stable(reg_rdata))
    else $error("rdata moved without tck");
  a_rdata_trst: assert property ((!trst_b) [*8] |-> $stable(reg_rdata))
    else $error("rdata moved in trst");
  a_break_on_fall: assert property ($stable(core_debug_clock) [*8] |-> $stable(break_hit))
    else $error("break_hit moved without fall");
endmodule // dwc_top_monitor

bind dwc_top dwc_top_monitor i_mon (.*);
`default_nettype wire

// File: test/dwc_far_end.sv
// Debugger scan port and core bus model facing the watchpoint block
`timescale 1ns/10ps
`default_nettype none
module dwc_far_end (
  input  wire logic        clk,
  input  wire logic [31:0] reg_rdata,
  output logic             tck,
  output logic             reg_update,
  output logic             reg_write,
  output logic [4:0]       reg_select,
  output logic [31:0]      reg_wdata,
  output logic             core_debug_clock,
  output logic [31:0]      core_addr,
  output logic [31:0]      core_data,
  output logic             fetch_n,
  output logic             direction_n,
  output logic [1:0]       access_size,
  output logic             privilege_n
);
  // Idle levels: both clocks stand still, core does word data accesses
  initial begin
    {tck, reg_update, reg_write, reg_select, reg_wdata, core_debug_clock} = '0;
    {core_addr, core_data} = '0;
    {fetch_n, direction_n, access_size, privilege_n} = 5'h1d;
  end

  // One register access over one test clock period; any time is legal
  task automatic scan(input logic wr, input logic [4:0] sel, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(negedge clk);
    reg_update = 1'b1;
    reg_write = wr;
    reg_select = sel;
    reg_wdata = wd;
    tck = 1'b1;
    repeat (4) @(negedge clk);
    tck = 1'b0;
    repeat (4) @(negedge clk);
    rd = reg_rdata;
    reg_update = 1'b0;
    reg_wdata = ~wd; // Released data shows no stale value
  endtask

  // One core bus cycle; the core clock is stopped between cycles
  task automatic cycle(input logic [31:0] a, input logic [31:0] d, input logic dn);
    @(negedge clk);
    core_addr = a;
    core_data = d;
    direction_n = dn;
    core_debug_clock = 1'b1;
    repeat (4) @(negedge clk);
    core_debug_clock = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule // dwc_far_end
`default_nettype wire

// File: test/dwc_top_bench.sv
// Self-checking bench of the debug watchpoint control block
`timescale 1ns/10ps
`default_nettype none
`include "dwc_map.vh"
module dwc_top_bench;
  logic clk = 1'b0, rst_b = 1'b0, trst_b = 1'b1, tap_idle = 1'b1;
  logic halt_request = 1'b0, core_halt_acknowledge = 1'b0;
  logic compact_isa_state = 1'b0, memory_request_n = 1'b1;
  logic [1:0] watch_extern = 2'h0;
  wire tck, reg_update, reg_write, core_debug_clock, fetch_n, direction_n, privilege_n;
  wire halt_request_internal, halt_acknowledge, irq_permit, break_hit;
  wire [4:0] reg_select;
  wire [1:0] access_size;
  wire [31:0] reg_wdata, core_addr, core_data, reg_rdata;
  logic [31:0] rd;
  int num_errors = 0;
  int checks_done = 0;
  // Rows: control[7:5] isa[4] done[3] -> request[2] ack[1] permit[0]
  logic [7:0] rows [8] = '{8'h09, 8'h32, 8'h45, 8'h7e, 8'h88, 8'hba, 8'hc4, 8'hf6};

  // ==========================================================================
  // Clock, design and far end
  always #10 clk = ~clk;
  dwc_top i_dut (.*);
  dwc_far_end i_far (.*);

  // ==========================================================================
  // Compare, access and closing tasks
  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] sel, input logic [31:0] v);
    i_far.scan(1'b1, sel, v, rd);
  endtask
  task automatic rdc(input logic [4:0] sel, input logic [31:0] exp);
    i_far.scan(1'b0, sel, 32'h0000_0000, rd);
    chk_word("reg_rdata", exp, rd);
  endtask
  task automatic core_chk(input logic [31:0] a, input logic [31:0] d, input logic dn,
                          input logic exp);
    i_far.cycle(a, d, dn);
    chk_bit("break_hit", exp, break_hit);
  endtask
  task automatic wrap_up;
    $display("Counts: %0d checks, %0d errors", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      compact_isa_state = rows[i][4];
      memory_request_n = rows[i][3];
      wr(`DWC_REG_CONTROL, {29'h0, rows[i][7:5]});
      chk_bit("halt_request_internal", rows[i][2], halt_request_internal);
      chk_bit("halt_acknowledge", rows[i][1], halt_acknowledge);
      chk_bit("irq_permit", rows[i][0], irq_permit);
      rdc(`DWC_REG_CONTROL, {29'h0, rows[i][7:5]});
      i_far.scan(1'b0, `DWC_REG_STATUS, 32'h0000_0000, rd);
      rdc(`DWC_REG_STATUS, {27'h0, rows[i][4:3], rows[i][0], rows[i][2:1]});
      $display("Test control row %0d done", i);
    end
    // Forced request waits for the idle state
    wr(`DWC_REG_CONTROL, 32'h0000_0000);
    tap_idle = 1'b0;
    wr(`DWC_REG_CONTROL, 32'h0000_0002);
    chk_bit("halt_request_internal", 1'b0, halt_request_internal);
    tap_idle = 1'b1;
    repeat (8) @(negedge clk);
    chk_bit("halt_request_internal", 1'b1, halt_request_internal);
    wr(`DWC_REG_CONTROL, 32'h0000_0000);
    halt_request = 1'b1;
    core_halt_acknowledge = 1'b1;
    repeat (8) @(negedge clk);
    chk_bit("halt_request_internal", 1'b1, halt_request_internal);
    chk_bit("halt_acknowledge", 1'b1, halt_acknowledge);
    chk_bit("irq_permit", 1'b0, irq_permit);
    halt_request = 1'b0;
    core_halt_acknowledge = 1'b0;
    $display("Test idle gate and pins done");
    // Test reset clears control and blocks writes; unmapped index reads zero
    wr(`DWC_REG_CONTROL, 32'h0000_0007);
    trst_b = 1'b0;
    wr(`DWC_REG_CONTROL, 32'h0000_0005);
    trst_b = 1'b1;
    repeat (4) @(negedge clk);
    rdc(`DWC_REG_CONTROL, 32'h0000_0000);
    compact_isa_state = 1'b0;
    memory_request_n = 1'b1;
    i_far.scan(1'b0, `DWC_REG_STATUS, 32'h0000_0000, rd);
    rdc(`DWC_REG_STATUS, 32'h0000_000c);
    rdc(5'h1f, 32'h0000_0000);
    $display("Test test reset and unmapped done");
    // Second system reset in mid-run
    wr(`DWC_REG_CONTROL, 32'h0000_0007);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    chk_bit("irq_permit", 1'b1, irq_permit);
    chk_bit("halt_acknowledge", 1'b0, halt_acknowledge);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    rdc(`DWC_REG_CONTROL, 32'h0000_0000);
    $display("Test mid-run reset done");
    // Watchpoint 0 as exact word write watch
    wr(5'h08, 32'h0000_1200);
    wr(5'h09, 32'h0000_0000);
    wr(5'h0b, 32'hffff_ffff);
    wr(5'h0d, 32'h0000_00f0);
    wr(5'h0c, 32'h0000_010d);
    core_chk(32'h0000_1200, 32'h0000_0000, 1'b1, 1'b1);
    core_chk(32'h0000_1200, 32'h0000_0000, 1'b0, 1'b0);
    core_chk(32'h0000_1204, 32'h0000_0000, 1'b1, 1'b0);
    wr(5'h09, 32'h0000_00ff);
    core_chk(32'h0000_1234, 32'h0000_0000, 1'b1, 1'b1);
    core_chk(32'h0000_1334, 32'h0000_0000, 1'b1, 1'b0);
    wr(5'h0a, 32'h0000_00a5);
    wr(5'h0b, 32'h0000_0000);
    core_chk(32'h0000_1234, 32'h0000_00a5, 1'b1, 1'b1);
    core_chk(32'h0000_1234, 32'h0000_005a, 1'b1, 1'b0);
    wr(5'h0c, 32'h0000_000d);
    core_chk(32'h0000_1234, 32'h0000_00a5, 1'b1, 1'b0);
    $display("Test address and data watch done");
    // Range pair: inside 256 bytes but not the first 32
    wr(5'h10, 32'h0000_0000);
    wr(5'h11, 32'h0000_001f);
    wr(5'h13, 32'hffff_ffff);
    wr(5'h15, 32'h0000_00ff);
    wr(5'h14, 32'h0000_0000);
    wr(5'h08, 32'h0000_0000);
    wr(5'h0b, 32'hffff_ffff);
    wr(5'h0d, 32'h0000_007f);
    wr(5'h0c, 32'h0000_0100);
    core_chk(32'h0000_0040, 32'h0000_0000, 1'b1, 1'b1);
    core_chk(32'h0000_0010, 32'h0000_0000, 1'b1, 1'b0);
    core_chk(32'h0000_0200, 32'h0000_0000, 1'b1, 1'b0);
    wr(5'h0d, 32'h0000_00bf);
    wr(5'h0c, 32'h0000_0140);
    core_chk(32'h0000_0040, 32'h0000_0000, 1'b1, 1'b1);
    wr(5'h14, 32'h0000_0000);
    core_chk(32'h0000_0040, 32'h0000_0000, 1'b1, 1'b0);
    $display("Test range coupling done");
    wrap_up();
  end
endmodule // dwc_top_bench
`default_nettype wire
